// ==== gsrq_pkg.sv ====
/*
 * Constants, field positions and types for the status-reporting and
 * service-request block of a remote-control interface.
 * Assumes the command parser and analyzer sit on the same clock.
 */
// Overview of operation
// - Test summary set by any enabled test event
// - Message-available bit follows pending response output
// - Standard summary set by any enabled standard event
// - Master summary when an enabled summary bit set
// - Request enable holds status byte bits 3-5; bits 0-2, 6, 7 dead
// - Request enable cleared at power-up
// - Raise service request on new enabled condition
// - Drop request after serial poll or conditions gone
// - Operation complete set only by completion command
// - Query error from the three query faults
// - Device error on lost data or overflow
// - Execution error on bad parameter or state
// - Command error on unknown or invalid command
// - Power-on bit set at power-up; two bits unused
// - Standard summary follows flags and enables; enable cleared
// - Window-end event at each window close
// - Test-end event at each finished test
// - Threshold event only while test runs
// - Sync-loss event on pattern lock loss
// - Phase-error event on detected phase error
// - Auto-sync event on lock; bits 6, 7 unused
// - Test summary follows flags, enables; enable cleared

package gsrq_pkg;

    // Status byte positions
    localparam int STB_TEST_SUMMARY_BIT = 3;
    localparam int STB_MAV = 4;
    localparam int STB_ESB = 5;
    localparam int STB_MSS = 6;
    localparam logic [7:0] SRE_USED = 8'h38;

    // Standard event positions
    localparam int ESR_OPC = 0;
    localparam int ESR_QYE = 2;
    localparam int ESR_DDE = 3;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam int ESR_PON = 7;
    localparam logic [7:0] ESR_USED = 8'hbd;

    // Test event positions
    localparam int TSR_WIN = 0;
    localparam int TSR_END = 1;
    localparam int TSR_THR = 2;
    localparam int TSR_SYN = 3;
    localparam int TSR_PHE = 4;
    localparam int TSR_AUT = 5;
    localparam logic [7:0] TSR_USED = 8'h3f;

    // Values after reset
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic PON_PEND_RST = 1'b1;

    // Register selectors for the command port
    typedef enum logic [2:0] {
        GSRQ_SEL_STB = 3'h0,
        GSRQ_SEL_SRE = 3'h1,
        GSRQ_SEL_ESR = 3'h2,
        GSRQ_SEL_ESE = 3'h3,
        GSRQ_SEL_TSR = 3'h4,
        GSRQ_SEL_TSE = 3'h5
    } gsrq_sel_t;

endpackage : gsrq_pkg

// ==== gsrq_evt_if.sv ====
/*
 * Carrier between the top and one event/enable register pair.
 * Assumes one clock domain.
 */
`timescale 1ns/10ps
`default_nettype none

interface gsrq_evt_if;
    logic [7:0] setEvt;
    logic clrFlags;
    logic enWr;
    logic [7:0] enData;
    logic [7:0] flags;
    logic [7:0] enable;
    logic summary;

    modport ctrl (
        output setEvt,
        output clrFlags,
        output enWr,
        output enData,
        input flags,
        input enable,
        input summary
    );
    modport evreg (
        input setEvt,
        input clrFlags,
        input enWr,
        input enData,
        output flags,
        output enable,
        output summary
    );
endinterface : gsrq_evt_if

`default_nettype wire

// ==== gsrq_event_reg.sv ====
/*
 * Sticky event register with its enable register and summary bit.
 * Assumes set pulses and clear strobes come from logic on clk_sys.
 */
`timescale 1ns/10ps
`default_nettype none

module gsrq_event_reg
    import gsrq_pkg::*;
#(
    parameter logic [7:0] USED_MASK = 8'hff
) (
    input wire logic clk_sys,
    input wire logic rstn,
    gsrq_evt_if.evreg port
);

    logic [7:0] flags_r;
    logic [7:0] enable_r;
    logic [7:0] flags_nxt;

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags, set beats clear
    always_comb begin
        flags_nxt = port.clrFlags ? REG_RST : flags_r;
        flags_nxt = flags_nxt | (port.setEvt & USED_MASK);
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            flags_r <= REG_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Enables, unused positions hold zero
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            enable_r <= REG_RST;
        end else if (port.enWr) begin
            enable_r <= port.enData & USED_MASK;
        end
    end

    assign port.flags = flags_r;
    assign port.enable = enable_r;
    assign port.summary = |(flags_r & enable_r);

    ////////////////////////////////////////////////////////////////////////
    a_flag_set_wins: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        |(port.setEvt & USED_MASK) |=>
        ((flags_r & $past(port.setEvt & USED_MASK))
            == $past(port.setEvt & USED_MASK)))
        else $error("event flag lost on set");

    a_flag_held: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !port.clrFlags && port.setEvt == REG_RST |=>
        (flags_r & $past(flags_r)) == $past(flags_r))
        else $error("event flag dropped without clear");

    a_enable_reset: assert property (@(posedge clk_sys)
        !rstn |=> enable_r == REG_RST)
        else $error("enable not cleared at power-up");

    a_unused_zero: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        ((flags_r | enable_r) & ~USED_MASK) == REG_RST)
        else $error("unused event position set");

endmodule : gsrq_event_reg

`default_nettype wire

// ==== gsrq_status_top.sv ====
/*
 * Status byte, request enable and service-request line, with the
 * standard and test event registers.
 * Assumes the parser, interface engine and analyzer drive one-cycle
 * pulses on clk_sys; srqOe drives an open-drain line low when high.
 */
`timescale 1ns/10ps
`default_nettype none

module gsrq_status_top
    import gsrq_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    // Parser and interface events
    input wire logic opcCmd,
    input wire logic queryNoOutput,
    input wire logic queryCmdWhilePending,
    input wire logic queryUnterminated,
    input wire logic inputDataLost,
    input wire logic inputOverflow,
    input wire logic paramRange,
    input wire logic paramCount,
    input wire logic stateBlocked,
    input wire logic cmdUnknown,
    input wire logic busCmdInvalid,
    input wire logic msgAvailable,
    input wire logic clsCmd,
    // Analyzer events
    input wire logic windowEnd,
    input wire logic testEnd,
    input wire logic testRunning,
    input wire logic erroredSecondHigh,
    input wire logic syncLoss,
    input wire logic phaseErr,
    input wire logic autoSyncLock,
    // Register command port
    input wire logic wrStrobe,
    input wire logic [2:0] wrSel,
    input wire logic [7:0] wrData,
    input wire logic rdStrobe,
    input wire logic [2:0] rdSel,
    output logic [7:0] rdData,
    output logic rdValid,
    // Serial poll and request line
    input wire logic serialPollDone,
    output logic [7:0] pollByte,
    output logic srqOut,
    output logic srqOe
);

    gsrq_evt_if stdIf ();
    gsrq_evt_if tstIf ();

    logic [7:0] sre_r;
    logic ponPend_r;
    logic srq_r;
    logic srq_nxt;
    logic mssPrev_r;
    logic [7:0] rdData_r;
    logic rdValid_r;
    logic [7:0] pollByte_r;
    logic [7:0] stb;
    logic mss;
    logic mssRise;

    function automatic logic selHit(
        input logic strobe,
        input logic [2:0] sel,
        input gsrq_sel_t which
    );
        selHit = strobe && (sel == which);
    endfunction : selHit

    ////////////////////////////////////////////////////////////////////////
    // Power-on event, caught one edge after reset release
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ponPend_r <= PON_PEND_RST;
        end else begin
            ponPend_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Standard event sources
    always_comb begin
        stdIf.setEvt = REG_RST;
        stdIf.setEvt[ESR_OPC] = opcCmd;
        stdIf.setEvt[ESR_QYE] = queryNoOutput || queryCmdWhilePending
            || queryUnterminated;
        stdIf.setEvt[ESR_DDE] = inputDataLost || inputOverflow;
        stdIf.setEvt[ESR_EXE] = paramRange || paramCount
            || stateBlocked;
        stdIf.setEvt[ESR_CME] = cmdUnknown || busCmdInvalid;
        stdIf.setEvt[ESR_PON] = ponPend_r;
    end

    // Clear on clear-status or on reading the register
    assign stdIf.clrFlags = clsCmd
        || selHit(rdStrobe, rdSel, GSRQ_SEL_ESR);
    assign stdIf.enWr = selHit(wrStrobe, wrSel, GSRQ_SEL_ESE);
    assign stdIf.enData = wrData;

    gsrq_event_reg #(
        .USED_MASK(ESR_USED)
    ) u_std (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .port(stdIf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Test event sources
    always_comb begin
        tstIf.setEvt = REG_RST;
        tstIf.setEvt[TSR_WIN] = windowEnd;
        tstIf.setEvt[TSR_END] = testEnd;
        tstIf.setEvt[TSR_THR] = testRunning && erroredSecondHigh;
        tstIf.setEvt[TSR_SYN] = syncLoss;
        tstIf.setEvt[TSR_PHE] = phaseErr;
        tstIf.setEvt[TSR_AUT] = autoSyncLock;
    end

    assign tstIf.clrFlags = clsCmd
        || selHit(rdStrobe, rdSel, GSRQ_SEL_TSR);
    assign tstIf.enWr = selHit(wrStrobe, wrSel, GSRQ_SEL_TSE);
    assign tstIf.enData = wrData;

    gsrq_event_reg #(
        .USED_MASK(TSR_USED)
    ) u_tst (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .port(tstIf)
    );

    ////////////////////////////////////////////////////////////////////////
    // Request enable
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            sre_r <= REG_RST;
        end else if (selHit(wrStrobe, wrSel, GSRQ_SEL_SRE)) begin
            sre_r <= wrData & SRE_USED;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte and master summary
    always_comb begin
        stb = REG_RST;
        stb[STB_TEST_SUMMARY_BIT] = tstIf.summary;
        stb[STB_MAV] = msgAvailable;
        stb[STB_ESB] = stdIf.summary;
        stb[STB_MSS] = mss;
    end

    // Taken from the summaries, not from stb, so no loop through bit 6
    assign mss = (tstIf.summary && sre_r[STB_TEST_SUMMARY_BIT])
        || (msgAvailable && sre_r[STB_MAV])
        || (stdIf.summary && sre_r[STB_ESB]);

    ////////////////////////////////////////////////////////////////////////
    // Service request line
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mssPrev_r <= 1'b0;
        end else begin
            mssPrev_r <= mss;
        end
    end

    assign mssRise = mss && !mssPrev_r;

    always_comb begin
        srq_nxt = srq_r;
        if (serialPollDone || !mss) begin
            srq_nxt = 1'b0;
        end
        if (mssRise) begin
            srq_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            srq_r <= 1'b0;
        end else begin
            srq_r <= srq_nxt;
        end
    end

    assign srqOut = 1'b0;
    assign srqOe = srq_r;

    // Byte returned in a serial poll
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            pollByte_r <= REG_RST;
        end else begin
            pollByte_r <= stb;
        end
    end

    assign pollByte = pollByte_r;

    ////////////////////////////////////////////////////////////////////////
    // Register reads
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdData_r <= REG_RST;
        end else if (rdStrobe) begin
            case (rdSel)
                GSRQ_SEL_STB: rdData_r <= stb;
                GSRQ_SEL_SRE: rdData_r <= sre_r;
                GSRQ_SEL_ESR: rdData_r <= stdIf.flags;
                GSRQ_SEL_ESE: rdData_r <= stdIf.enable;
                GSRQ_SEL_TSR: rdData_r <= tstIf.flags;
                GSRQ_SEL_TSE: rdData_r <= tstIf.enable;
                default: rdData_r <= REG_RST;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdValid_r <= 1'b0;
        end else begin
            rdValid_r <= rdStrobe;
        end
    end

    assign rdData = rdData_r;
    assign rdValid = rdValid_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_newCondition;
        !mss ##1 mss;
    endsequence

    sequence s_srqUp;
        srqOe;
    endsequence

    a_srq_raise: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        s_newCondition |=> s_srqUp)
        else $error("request not raised on new condition");

    a_srq_poll: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        srqOe && serialPollDone && !mssRise |=> !srqOe)
        else $error("request held after serial poll");

    a_srq_gone: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !mss |=> !srqOe)
        else $error("request held with no enabled condition");

    a_srq_cause: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(srqOe) |-> $past(mss) && !$past(mssPrev_r))
        else $error("request raised without new condition");

    a_mss_enabled: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        pollByte[STB_MSS] == (($past(tstIf.summary)
            && $past(sre_r[STB_TEST_SUMMARY_BIT]))
            || ($past(msgAvailable) && $past(sre_r[STB_MAV]))
            || ($past(stdIf.summary) && $past(sre_r[STB_ESB]))))
        else $error("master summary disagrees with enabled sources");

    a_sre_bit7: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        !sre_r[STB_MSS] && !sre_r[7])
        else $error("undefined request enable bit set");

    a_sre_powerup: assert property (@(posedge clk_sys)
        !rstn ##1 rstn |-> sre_r == REG_RST)
        else $error("request enable not cleared at power-up");

    a_pon_event: assert property (@(posedge clk_sys)
        !rstn ##1 rstn |=> stdIf.flags[ESR_PON])
        else $error("power-on bit not set after power-up");

    a_opc_cause: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(stdIf.flags[ESR_OPC]) |-> $past(opcCmd))
        else $error("operation complete set without command");

    a_thr_gate: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        $rose(tstIf.flags[TSR_THR])
            |-> $past(testRunning) && $past(erroredSecondHigh))
        else $error("threshold event outside a running test");

    a_esb_follow: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        stdIf.enWr && |(stdIf.flags & wrData) && !stdIf.clrFlags
            |=> stb[STB_ESB])
        else $error("standard summary not re-evaluated");

    a_tsum_follow: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        tstIf.enWr && |(tstIf.flags & wrData) && !tstIf.clrFlags
            |=> stb[STB_TEST_SUMMARY_BIT])
        else $error("test summary not re-evaluated");

    a_read_clear: assert property (
        @(posedge clk_sys) disable iff (!rstn)
        selHit(rdStrobe, rdSel, GSRQ_SEL_TSR) && tstIf.setEvt == REG_RST
            |=> rdValid && rdData == $past(tstIf.flags)
            && tstIf.flags == REG_RST)
        else $error("test event read did not return and clear");

endmodule : gsrq_status_top

`default_nettype wire

// ==== gsrq_ctl_model.sv ====
/*
 * Bus controller model: answers a raised service request with a
 * serial poll after a programmable wait and keeps the polled byte.
 * Assumes the same clk_sys and rstn as the status block.
 */
`timescale 1ns/10ps
`default_nettype none

module gsrq_ctl_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic srqOe,
    input wire logic [7:0] pollByte,
    input wire logic pollEn,
    input wire logic [3:0] pollDelay,
    output var logic serialPollDone,
    output var logic [7:0] polledByte,
    output var int nPolls
);
    logic [3:0] waitCnt_r;

    // Poll once per request, after pollDelay cycles of waiting
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            serialPollDone <= 1'b0;
            polledByte <= 8'h00;
            nPolls <= 0;
            waitCnt_r <= 4'h0;
        end else begin
            serialPollDone <= 1'b0;
            if (pollEn && srqOe && !serialPollDone) begin
                if (waitCnt_r == pollDelay) begin
                    serialPollDone <= 1'b1;
                    polledByte <= pollByte;
                    nPolls <= nPolls + 1;
                    waitCnt_r <= 4'h0;
                end else begin
                    waitCnt_r <= waitCnt_r + 4'h1;
                end
            end else begin
                waitCnt_r <= 4'h0;
            end
        end
    end
endmodule : gsrq_ctl_model

`default_nettype wire

// ==== gpib_status_srq_reporting_bench.sv ====
/*
 * Self-checking bench for the status block: event scan, clear-status,
 * random enables and events with request and poll checks.
 * Assumes gsrq_pkg, gsrq_status_top and gsrq_ctl_model are compiled.
 */
`timescale 1ns/10ps
`default_nettype none

module gpib_status_srq_reporting_bench
    import gsrq_pkg::*;
;
    localparam logic [7:0] EV_MASK [17] = '{8'h01, 8'h04, 8'h04, 8'h04,
        8'h08, 8'h08, 8'h10, 8'h10, 8'h10, 8'h20, 8'h20,
        8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic [16:0] ev, v;
    logic testRunning, msgAvailable, clsCmd, wrStrobe, rdStrobe;
    logic pollEn, serialPollDone, rdValid, srqOut, srqOe, run, mav;
    logic [2:0] wrSel, rdSel;
    logic [7:0] wrData, rdData, pollByte, polledByte, sre, ese, tse, s;
    logic [3:0] pollDelay;
    logic [15:0] f;
    int nPolls, nMismatch, nTests, n0;

    always #2 clk_sys = ~clk_sys;

    gsrq_status_top dut (.clk_sys(clk_sys), .rstn(rstn),
        .opcCmd(ev[0]), .queryNoOutput(ev[1]),
        .queryCmdWhilePending(ev[2]), .queryUnterminated(ev[3]),
        .inputDataLost(ev[4]), .inputOverflow(ev[5]),
        .paramRange(ev[6]), .paramCount(ev[7]), .stateBlocked(ev[8]),
        .cmdUnknown(ev[9]), .busCmdInvalid(ev[10]),
        .msgAvailable(msgAvailable), .clsCmd(clsCmd),
        .windowEnd(ev[11]), .testEnd(ev[12]), .testRunning(testRunning),
        .erroredSecondHigh(ev[13]), .syncLoss(ev[14]),
        .phaseErr(ev[15]), .autoSyncLock(ev[16]),
        .wrStrobe(wrStrobe), .wrSel(wrSel), .wrData(wrData),
        .rdStrobe(rdStrobe), .rdSel(rdSel), .rdData(rdData),
        .rdValid(rdValid), .serialPollDone(serialPollDone),
        .pollByte(pollByte), .srqOut(srqOut), .srqOe(srqOe));

    gsrq_ctl_model ctl (.clk_sys(clk_sys), .rstn(rstn), .srqOe(srqOe),
        .pollByte(pollByte), .pollEn(pollEn), .pollDelay(pollDelay),
        .serialPollDone(serialPollDone), .polledByte(polledByte),
        .nPolls(nPolls));

    ////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] expFlags(input logic [16:0] e,
                                             input logic r);
        logic [15:0] x;
        x = 16'h0000;
        for (int i = 0; i < 17; i++) begin
            if (e[i] && (i != 13 || r)) begin
                if (i < 11) x[7:0] |= EV_MASK[i];
                else x[15:8] |= EV_MASK[i];
            end
        end
        return x;
    endfunction : expFlags

    function automatic logic [7:0] expStb(input logic [15:0] x,
        input logic m, input logic [7:0] en0, en1, en2);
        logic tsum, esb, mss;
        tsum = |(x[15:8] & en2 & 8'h3f);
        esb = |(x[7:0] & en1 & 8'hbd);
        mss = |({esb, m, tsum} & en0[5:3]);
        return {1'b0, mss, esb, m, tsum, 3'h0};
    endfunction : expStb

    task summarize;
        if (nMismatch == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        nTests++;
        if (seen !== exp) begin
            nMismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : chk

    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : tick

    task wr(input logic [2:0] sel, input logic [7:0] d);
        @(posedge clk_sys);
        wrStrobe <= 1'b1;
        wrSel <= sel;
        wrData <= d;
        @(posedge clk_sys);
        wrStrobe <= 1'b0;
    endtask : wr

    // Read answer lands exactly one cycle after the strobe edge
    task rdChk(input logic [2:0] sel, input logic [7:0] exp);
        @(posedge clk_sys);
        rdStrobe <= 1'b1;
        rdSel <= sel;
        @(posedge clk_sys);
        rdStrobe <= 1'b0;
        #1;
        chk({7'h00, rdValid}, 8'h01);
        chk(rdData, exp);
    endtask : rdChk

    task pulse(input logic [16:0] e, input logic c);
        @(posedge clk_sys);
        ev <= e;
        clsCmd <= c;
        @(posedge clk_sys);
        ev <= 17'h00000;
        clsCmd <= 1'b0;
    endtask : pulse

    task waitPoll;
        int t;
        t = 0;
        while (nPolls == n0 && t < 30) begin
            @(posedge clk_sys);
            #1;
            t++;
        end
        if (nPolls == n0) begin
            nMismatch++;
            summarize;
        end
    endtask : waitPoll

    ////////////////////////////////////////////////////////////////////
    initial begin
        ev = 17'h00000;
        {testRunning, msgAvailable, clsCmd, wrStrobe, rdStrobe} = 5'h00;
        {wrSel, rdSel, wrData, pollEn, pollDelay} = 19'h00000;
        nMismatch = 0;
        nTests = 0;
        void'($urandom(32'hd97682c4));
        repeat (6) @(posedge clk_sys);
        rstn <= 1'b1;
        tick(3);
        rdChk(GSRQ_SEL_ESR, 8'h80);
        rdChk(GSRQ_SEL_ESR, 8'h00);
        rdChk(GSRQ_SEL_SRE, 8'h00);
        rdChk(GSRQ_SEL_ESE, 8'h00);
        rdChk(GSRQ_SEL_TSE, 8'h00);
        rdChk(GSRQ_SEL_STB, 8'h00);
        rdChk(3'h6, 8'h00);
        // One source at a time, threshold event also without a test
        for (int i = 0; i < 18; i++) begin
            v = 17'h00001 << ((i == 17) ? 13 : i);
            run = (i != 17);
            testRunning <= run;
            pulse(v, 1'b0);
            f = expFlags(v, run);
            tick(4);
            rdChk(GSRQ_SEL_ESR, f[7:0]);
            rdChk(GSRQ_SEL_TSR, f[15:8]);
        end
        // Clear-status, and writes to read-only places
        pulse(17'h1ffff, 1'b0);
        pulse(17'h00000, 1'b1);
        wr(GSRQ_SEL_ESR, 8'hff);
        wr(GSRQ_SEL_TSR, 8'hff);
        wr(GSRQ_SEL_STB, 8'hff);
        rdChk(GSRQ_SEL_ESR, 8'h00);
        rdChk(GSRQ_SEL_TSR, 8'h00);
        for (int k = 0; k < 40; k++) begin
            sre = 8'($urandom);
            ese = 8'($urandom);
            tse = 8'($urandom);
            v = 17'($urandom);
            run = 1'($urandom);
            mav = 1'($urandom);
            testRunning <= run;
            msgAvailable <= mav;
            pulse(v, 1'b0);
            // Enables after the events, so summaries must follow them
            wr(GSRQ_SEL_SRE, sre);
            wr(GSRQ_SEL_ESE, ese);
            wr(GSRQ_SEL_TSE, tse);
            rdChk(GSRQ_SEL_SRE, sre & 8'h38);
            rdChk(GSRQ_SEL_ESE, ese & 8'hbd);
            rdChk(GSRQ_SEL_TSE, tse & 8'h3f);
            f = expFlags(v, run);
            s = expStb(f, mav, sre, ese, tse);
            tick(3);
            chk({7'h00, srqOe}, {7'h00, s[6]});
            chk({7'h00, srqOut}, 8'h00);
            rdChk(GSRQ_SEL_STB, s);
            if (s[6] && k[0]) begin
                pollDelay <= 4'($urandom);
                pollEn <= 1'b1;
                n0 = nPolls;
                waitPoll;
                chk(polledByte, s);
                tick(2);
                pollEn <= 1'b0;
                chk({7'h00, srqOe}, 8'h00);
            end
            msgAvailable <= 1'b0;
            rdChk(GSRQ_SEL_ESR, f[7:0]);
            rdChk(GSRQ_SEL_TSR, f[15:8]);
            tick(3);
            chk({7'h00, srqOe}, 8'h00);
            rdChk(GSRQ_SEL_STB, 8'h00);
        end
        summarize;
    end
endmodule : gpib_status_srq_reporting_bench

`default_nettype wire
